/* File: dv/fsq_fault_sequencer_properties.sv */
// port assertions of the fault sequencer
`timescale 1ns/1ps
module fsq_fault_sequencer_properties import fsq_pkg::*; #(
  parameter int PERIOD_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // inputs
  input wire fsq_faults_t faults,
  input wire logic pwm_request,
  input wire logic dim_request,
  input wire logic [PERIOD_W-1:0] osc_period,
  // outputs
  input wire fsq_drive_t drive,
  input wire logic switch_tick
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // period and timing-pin fault age
  // ----------------------------------------
  logic [15:0] gap;
  logic [15:0] tpf;
  always_ff @(posedge clk) begin
    if (reset) begin
      gap <= 16'h0000;
      tpf <= 16'h0000;
    end else begin
      gap <= switch_tick ? 16'h0001 : gap + 16'h0001;
      tpf <= faults.timing_pin_fault ? tpf + 16'h0001 : 16'h0000;
    end
  end
  chk_flag_any: assert property ((faults.led_oc | faults.fixed_ov | faults.prog_ov | faults.supply_uv |
    faults.rail_uv | faults.overtemp | faults.series_uv) |-> ##[1:2] !drive.fault_flag_n) else $error("flag missing");
  chk_ov_led_off: assert property ((faults.led_oc | faults.fixed_ov | faults.prog_ov) |=>
    !drive.low_side_gate_drive && !drive.series_switch_drive) else $error("drives on after trip");
  chk_hold_off: assert property ((faults.supply_uv | faults.series_uv) |-> ##[1:2]
    (!drive.low_side_gate_drive && !drive.series_switch_drive)) else $error("drives on in hold");
  chk_low_only: assert property ((faults.rail_uv | faults.overtemp) |=> !drive.low_side_gate_drive)
    else $error("low side on");
  chk_pulse_end: assert property (faults.low_side_oc |=> !drive.low_side_gate_drive)
    else $error("pulse not ended");
  chk_min_duty: assert property (faults.comp_short |=> drive.min_duty) else $error("duty not limited");
  chk_hiccup_hold: assert property (drive.soft_start_discharge |->
    (!drive.low_side_gate_drive && !drive.fault_flag_n)) else $error("released in hiccup");
  chk_default_freq: assert property ((switch_tick && tpf > 16'h0258) |-> gap == 16'h011D)
    else $error("default period wrong");
  cov_hiccup: cover property ($rose(drive.soft_start_discharge));
  cov_min_duty: cover property (drive.min_duty && faults.comp_short);
  cov_default: cover property (switch_tick && tpf > 16'h0258);
endmodule : fsq_fault_sequencer_properties

bind fsq_fault_sequencer fsq_fault_sequencer_properties #(.PERIOD_W(PERIOD_W)) u_fsq_props (.clk(clk),
  .reset(reset), .faults(faults), .pwm_request(pwm_request), .dim_request(dim_request),
  .osc_period(osc_period), .drive(drive), .switch_tick(switch_tick));

/* File: dv/fsq_fault_sequencer_tb.sv */
// self-checking bench of the fault sequencer
`timescale 1ns/1ps
module fsq_fault_sequencer_tb import fsq_pkg::*;;
  localparam int HIC = 200;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pwm_request = 1'b0;
  logic dim_request = 1'b0;
  logic [15:0] osc_period = 16'h0014;
  logic [10:0] cond = '0;
  fsq_faults_t faults;
  fsq_drive_t drive;
  logic switch_tick;
  int miscompares = 0;
  int checked = 0;
  int ticks = 0;
  int hi = 0;
  int rise_ticks = 0;
  int got;
  int e;
  int m;
  int exp_q[$];
  int msk_q[$];
  int tbl[11] = '{9, 7, 6, 5, 3, 2, 4, 0, 10, 8, 1};
  fsq_stage_model u_fsq_stage_model (.clk(clk), .reset(reset), .cond(fsq_faults_t'(cond)), .faults(faults));
  fsq_fault_sequencer #(.HICCUP_CYCLES(HIC), .BLANK_CYCLES(100)) u_fsq_fault_sequencer (.clk(clk),
    .reset(reset), .faults(faults), .pwm_request(pwm_request), .dim_request(dim_request),
    .osc_period(osc_period), .drive(drive), .switch_tick(switch_tick));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    if (miscompares == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic wait_out(input int sel, input logic v);
    int n;
    n = 0;
    while ((sel == 0 ? drive.soft_start_discharge : drive.soft_start_active) !== v && n < 5000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 5000) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, !v, v);
    end
  endtask : wait_out
  // apply one fault just after a tick; hold 0 means until the hiccup starts
  task automatic hit(input int b, input int hold, input int ev, input int mv);
    @(posedge clk iff switch_tick === 1'b1);
    @(posedge clk);
    ticks <= 0;
    cond[b] <= 1'b1;
    if (mv != 0) begin
      exp_q.push_back(ev);
      msk_q.push_back(mv);
    end
    repeat (hold) @(posedge clk);
    if (hold == 0) wait_out(0, 1'b1);
    cond[b] <= 1'b0;
    repeat (3) @(posedge clk);
    wait_out(0, 1'b0);
    repeat (3) @(posedge clk);
    wait_out(1, 1'b0);
  endtask : hit
  always @(posedge clk) begin
    pwm_request <= ($urandom % 4) != 0;
  end
  // result: ticks before the hiccup starts and cycles it stands
  always @(posedge clk) begin
    if (switch_tick === 1'b1) ticks <= ticks + 1;
    if (drive.soft_start_discharge === 1'b1) begin
      hi <= hi + 1;
      if (hi == 0) rise_ticks <= ticks;
    end else if (hi != 0) begin
      hi <= 0;
      got = (rise_ticks << 16) | hi;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hFFFFFFFF;
      m = (msk_q.size() > 0) ? msk_q.pop_front() : 32'hFFFFFFFF;
      checked++;
      if (((got ^ e) & m) != 0) begin
        miscompares++;
        $display("CHECK FAILED %0t got %h exp %h", $time, got, e);
      end
    end
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h75EEB440));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    dim_request <= 1'b1;
    osc_period <= 16'(16 + $urandom % 25);
    repeat (3) @(posedge clk);
    wait_out(1, 1'b0);
    hit(10, 0, (65 << 16) | HIC, 32'hFFFFFFFF);
    hit(8, 0, (31 << 16) | HIC, 32'hFFFFFFFF);
    cond[10] <= 1'b1;
    repeat (40) @(posedge clk iff switch_tick === 1'b1);
    cond[10] <= 1'b0;
    repeat (3) @(posedge clk iff switch_tick === 1'b1);
    hit(10, 0, (65 << 16) | HIC, 32'hFFFFFFFF);
    foreach (tbl[i]) hit(tbl[i], (tbl[i] == 1) ? 1500 : 5 + $urandom % 36, 0, (i < 6) ? 32'hFFFF0000 : 0);
    repeat (20) @(posedge clk);
    if (exp_q.size() != 0) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h exp %h", $time, exp_q.size(), 0);
    end
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    stop_test();
  end
endmodule : fsq_fault_sequencer_tb

/* File: dv/fsq_stage_model.sv */
// behavioural power stage and fault comparators
`timescale 1ns/1ps
module fsq_stage_model import fsq_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // condition set by the bench
  input wire fsq_faults_t cond,
  // toward the sequencer
  output fsq_faults_t faults
);
  // comparators settle one clock after the condition
  always_ff @(posedge clk) begin
    if (reset) begin
      faults <= '0;
    end else begin
      faults <= cond;
    end
  end
endmodule : fsq_stage_model

/* File: hw/fsq_defines.svh */
// constants of the led driver fault sequencer
//
// Summary of operation
// - a low-side overcurrent ends the switching pulse early, every cycle, with no latched fault
// - an overcurrent lasting beyond 64 switching cycles stops both drives, flags, hiccups, restarts
// - the current-limit fault count and the output-undervoltage input are ignored for 3 ms during startup
// - LED overcurrent stops both drives and flags at once; hiccup after 2 cycles
// - output undervoltage stops drives at once; beyond 30 cycles hiccup, then soft-start
// - either overvoltage stops both drives and flags at once; hiccup after 1 cycle
// - input undervoltage stops both drives and flags; soft-start restart once supply recovers
// - regulator rail undervoltage stops only the low-side drive and flags until recovery
// - overtemperature stops the low-side drive and flags; soft-start restart once cooled
// - series-switch drive undervoltage stops both drives, flags, then soft-start restart
// - a faulted timing pin makes the oscillator run at the 350 kHz default
// - a shorted error-amplifier output holds the regulator at minimum duty cycle
// - every hiccup period lasts 26.5 ms before the restart sequence, unless a hold fault (hold_req) ends it early
// - fault counts are measured in switching clock cycles
// - the soft-start node is discharged at once when a hiccup period begins
// - the active-low fault flag is asserted for any unblanked fault except cycle-by-cycle overcurrent, timing-pin and error-amplifier faults
`ifndef FSQ_DEFINES_SVH
`define FSQ_DEFINES_SVH

`define FSQ_CLK_HZ 100000000
`define FSQ_DEFAULT_OSC_HZ 350000
`define FSQ_DEFAULT_PERIOD (`FSQ_CLK_HZ / `FSQ_DEFAULT_OSC_HZ)
`define FSQ_HICCUP_MS 26.5
`define FSQ_BLANK_MS 3.0
`define FSQ_OC_COUNT 64
`define FSQ_UV_COUNT 30
`define FSQ_LED_MASK_COUNT 2
`define FSQ_OV_MASK_COUNT 1
`define FSQ_MIN_ON_CYCLES 16'h000A
`define FSQ_MIN_PERIOD 16'h0002

`endif

/* File: hw/fsq_fault_sequencer.sv */
// fault sequencer of the led current controller
`timescale 1ns/1ps
`include "fsq_defines.svh"
module fsq_fault_sequencer import fsq_pkg::*; #(
  parameter int PERIOD_W = 16,
  parameter int TIMER_W = 22,
  parameter int HICCUP_CYCLES = int'(`FSQ_HICCUP_MS * `FSQ_CLK_HZ / 1000.0),
  parameter int BLANK_CYCLES = int'(`FSQ_BLANK_MS * `FSQ_CLK_HZ / 1000.0)
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // fault indications
  input wire fsq_faults_t faults,
  // loop requests
  input wire logic pwm_request,
  input wire logic dim_request,
  input wire logic [PERIOD_W-1:0] osc_period,
  // power stage
  output fsq_drive_t drive,
  output logic switch_tick
);

  localparam int CNT_W = 8;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  wire logic [PERIOD_W-1:0] phase;

  fsq_switch_osc #(
    .W(PERIOD_W)
  ) u_osc (
    .clk(clk),
    .reset(reset),
    .period(osc_period),
    .use_default(faults.timing_pin_fault),
    .tick(switch_tick),
    .phase(phase)
  );

  // ----------------------------------------------------------------
  // state and timers
  // ----------------------------------------------------------------
  fsq_state_t state;
  fsq_state_t next_state;
  logic [CNT_W-1:0] mask_limit;

  wire logic blank_done;
  wire logic hiccup_done;
  wire logic mask_done;
  wire logic oc_trip;
  wire logic uv_trip;

  wire logic in_start = state == S_START;
  wire logic in_run = state == S_RUN;
  wire logic in_mask = state == S_MASK;
  wire logic in_hiccup = state == S_HICCUP;
  wire logic in_hold = state == S_HOLD;
  wire logic running = in_start || in_run;

  // startup blanking of the current limit and output undervoltage
  wire logic blanking = in_start && !blank_done;
  wire logic oc_seen = faults.low_side_oc && !blanking;
  wire logic uv_seen = faults.output_uv && !blanking;
  wire logic ov_any = faults.fixed_ov || faults.prog_ov;
  wire logic hold_req = faults.supply_uv || faults.overtemp || faults.series_uv;
  wire logic mask_req = faults.led_oc || ov_any;
  wire logic [CNT_W-1:0] new_mask_limit = ov_any ? CNT_W'(`FSQ_OV_MASK_COUNT) : CNT_W'(`FSQ_LED_MASK_COUNT);

  fsq_step_counter #(
    .W(TIMER_W)
  ) u_blank (
    .clk(clk),
    .reset(reset),
    .run(in_start),
    .step(1'b1),
    // count starts at zero on the entry cycle, so the last blanked cycle is one short of the span
    .limit(TIMER_W'(BLANK_CYCLES - 1)),
    .done(blank_done)
  );

  fsq_step_counter #(
    .W(TIMER_W)
  ) u_hiccup (
    .clk(clk),
    .reset(reset),
    .run(in_hiccup),
    .step(1'b1),
    // hiccup state stands exactly HICCUP_CYCLES cycles
    .limit(TIMER_W'(HICCUP_CYCLES - 1)),
    .done(hiccup_done)
  );

  // counts switching ticks spent in the mask interval
  fsq_step_counter #(
    .W(CNT_W)
  ) u_mask (
    .clk(clk),
    .reset(reset),
    .run(in_mask),
    .step(switch_tick),
    .limit(mask_limit),
    .done(mask_done)
  );

  // trips one count past the threshold
  fsq_step_counter #(
    .W(CNT_W)
  ) u_oc (
    .clk(clk),
    .reset(reset),
    .run(oc_seen && running),
    .step(switch_tick),
    .limit(CNT_W'(`FSQ_OC_COUNT + 1)),
    .done(oc_trip)
  );

  fsq_step_counter #(
    .W(CNT_W)
  ) u_uv (
    .clk(clk),
    .reset(reset),
    .run(uv_seen && running),
    .step(switch_tick),
    .limit(CNT_W'(`FSQ_UV_COUNT + 1)),
    .done(uv_trip)
  );

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      S_START, S_RUN: begin
        if (hold_req) begin
          next_state = S_HOLD;
        end else if (mask_req) begin
          next_state = S_MASK;
        end else if (oc_trip || uv_trip) begin
          next_state = S_HICCUP;
        end else if (in_start && blank_done) begin
          next_state = S_RUN;
        end
      end
      S_MASK: begin
        if (hold_req) begin
          next_state = S_HOLD;
        end else if (mask_done) begin
          next_state = S_HICCUP;
        end
      end
      S_HICCUP: begin
        if (hold_req) begin
          next_state = S_HOLD;
        end else if (hiccup_done) begin
          next_state = S_START;
        end
      end
      S_HOLD: begin
        if (!hold_req) begin
          next_state = S_START;
        end
      end
      default: begin
        next_state = S_START;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= S_START;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      mask_limit <= CNT_W'(`FSQ_OV_MASK_COUNT);
    end else if (running && mask_req) begin
      mask_limit <= new_mask_limit;
    end
  end

  // ----------------------------------------------------------------
  // switching pulse
  // ----------------------------------------------------------------
  logic pulse_on;
  wire logic min_on_end = faults.comp_short && (phase >= PERIOD_W'(`FSQ_MIN_ON_CYCLES));
  wire logic pulse_end = faults.low_side_oc || min_on_end;
  wire logic next_pulse_on = switch_tick ? 1'b1 : (pulse_end ? 1'b0 : pulse_on);

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_on <= 1'b0;
    end else begin
      pulse_on <= next_pulse_on;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  wire logic both_off = faults.led_oc || ov_any || faults.supply_uv || faults.series_uv || uv_seen;
  wire logic low_off = both_off || faults.rail_uv || faults.overtemp;
  wire logic fault_any = both_off || faults.rail_uv || faults.overtemp || oc_trip || !running;

  fsq_drive_t next_drive;

  always_comb begin
    next_drive.low_side_gate_drive = running && !low_off && pulse_on && !pulse_end && pwm_request;
    next_drive.series_switch_drive = running && !both_off && dim_request;
    next_drive.fault_flag_n = !fault_any;
    next_drive.soft_start_discharge = in_hiccup || in_mask || in_hold;
    next_drive.soft_start_active = in_start;
    next_drive.min_duty = faults.comp_short;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      drive <= '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    end else begin
      drive <= next_drive;
    end
  end

endmodule : fsq_fault_sequencer

/* File: hw/fsq_pkg.sv */
// types shared by the led driver fault sequencer
package fsq_pkg;

  // fault indications from the analog comparators
  typedef struct packed {
    logic low_side_oc;
    logic led_oc;
    logic output_uv;
    logic fixed_ov;
    logic prog_ov;
    logic supply_uv;
    logic rail_uv;
    logic overtemp;
    logic series_uv;
    logic timing_pin_fault;
    logic comp_short;
  } fsq_faults_t;

  // drive and status outputs toward the power stage
  typedef struct packed {
    logic low_side_gate_drive;
    logic series_switch_drive;
    logic fault_flag_n;
    logic soft_start_discharge;
    logic soft_start_active;
    logic min_duty;
  } fsq_drive_t;

  typedef enum logic [4:0] {
    S_START  = 5'h01,
    S_RUN    = 5'h02,
    S_MASK   = 5'h04,
    S_HICCUP = 5'h08,
    S_HOLD   = 5'h10
  } fsq_state_t;

endpackage : fsq_pkg

/* File: hw/fsq_step_counter.sv */
// saturating step counter, cleared whenever run is low
`timescale 1ns/1ps
module fsq_step_counter import fsq_pkg::*; #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic step,
  input wire logic [W-1:0] limit,
  // status
  output logic done
);

  logic [W-1:0] count;
  wire logic at_limit = count >= limit;
  wire logic [W-1:0] next_count = !run ? '0 : (step && !at_limit) ? count + W'(1) : count;

  always_ff @(posedge clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  assign done = run && at_limit;

endmodule : fsq_step_counter

/* File: hw/fsq_switch_osc.sv */
// switching oscillator: one tick per switching period
`timescale 1ns/1ps
`include "fsq_defines.svh"
module fsq_switch_osc import fsq_pkg::*; #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic [W-1:0] period,
  input wire logic use_default,
  // timing
  output logic tick,
  output logic [W-1:0] phase
);

  wire logic bad_period = period < W'(`FSQ_MIN_PERIOD);
  wire logic [W-1:0] cur_period = (use_default || bad_period) ? W'(`FSQ_DEFAULT_PERIOD) : period;
  wire logic wrap = phase >= cur_period - W'(1);
  wire logic [W-1:0] next_phase = wrap ? '0 : phase + W'(1);

  always_ff @(posedge clk) begin
    if (reset) begin
      phase <= '0;
      tick <= 1'b0;
    end else begin
      phase <= next_phase;
      tick <= wrap;
    end
  end

endmodule : fsq_switch_osc
